// >>> src/ssb_bridge.sv
// Serial bridge between on-chip TDM and SPI controllers and an external line-interface chip.
// Assumes the on-chip controllers share i_clock; pin inputs arrive asynchronously.
// What this block does
// - External loopback copies the receive pin to the transmit pin without any sampling.
// - Four-wire mode merges codec control port and PCM voice onto one serial link.
// - Mode field at GPIO offset 0x60: code 1 picks four-wire mode; codes 0 and 3 give plain TDM.
// - Four-wire link runs on a 50 MHz line clock in place of 49.152 MHz; TDM clock divides it.
// - Four-wire TDM bit clock must lie between 1.024 and 8.192 MHz.
// - Four-wire SPI serial clock may run up to 8.192 MHz.
// - Four-wire interrupt is inverted and synchronised into the system clock domain.
// - Active bridge uses the TDM pins and keeps SPI chip select 3 internal.
// - SPI data is sampled and launched on the rising serial clock edge.
// - Same mode field picks three-wire mode, carrying TDM and SPI over three pins.
// - Three-wire link runs on 25 MHz line clock in place of 24 MHz; TDM clock 1.536 to 2.048 MHz.
// - Three-wire SPI serial clock must stay between 3 and 4 MHz.
// - Shared pins serve exactly one function: three-wire, four-wire or plain TDM.
`timescale 1ns/1ns

module ssb_bridge import ssb_pkg::*; #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic i_clock, // System clock, 100 MHz.
	input wire logic i_reset, // Asynchronous reset, active high.
	input wire logic [1:0] i_mode_sel, // Mode field of the GPIO register.
	input wire logic i_bridge_reset, // Bridge held in reset, active high.
	input wire logic i_ext_loopback, // Remote loopback enable.
	input wire logic [7:0] i_tdm_div, // Line clock periods per TDM bit.
	input wire logic i_tdm_ck, // On-chip TDM clock for plain TDM.
	input wire logic i_tdm_fs, // On-chip frame sync.
	input wire logic i_tdm_fs_oe, // On-chip frame sync drive enable.
	input wire logic i_tdm_transmit_data, // On-chip TDM transmit data.
	input wire logic i_tdm_transmit_data_oe, // On-chip transmit data drive enable.
	output logic o_tdm_receive_data, // Receive data towards on-chip TDM.
	output logic o_tdm_fs, // Frame sync from pin towards on-chip TDM.
	output logic o_tdm_bit_clk, // Derived TDM bit clock in bridge modes.
	input wire logic i_spi_sclk, // On-chip SPI serial clock.
	input wire logic i_spi_mosi, // On-chip SPI data out.
	input wire logic i_spi_cs3_n, // On-chip chip select 3, active low.
	output logic o_spi_miso, // SPI data back to the controller.
	output logic o_spi_cs3_pin_n, // Chip select 3 pin, active low.
	output logic o_pin_ck, // Clock pin.
	output logic o_pin_fs, // Frame sync pin value.
	output logic o_pin_fs_oe, // Frame sync pin drive enable.
	input wire logic i_pin_fs, // Frame sync pin level.
	output logic o_pin_dx, // Transmit data pin value.
	output logic o_pin_dx_oe, // Transmit data pin drive enable.
	input wire logic i_pin_dr, // Receive data pin level.
	input wire logic i_line_int_n, // Line chip interrupt, active low.
	output logic [1:0] o_mode_active, // Mode in force.
	output logic o_irq, // Interrupt to the processor.
	output logic o_cfg_error, // TDM clock outside the mode's range.
	output logic o_spi_error, // SPI rate or frame length wrong.
	output logic o_overrun, // PCM word lost for want of room.
	output logic o_pcm_ready // Room in the PCM buffer.
);
	localparam int LINE4_HALF = (`SSB_LINE4_HALF_RAW < 1) ? 1 : `SSB_LINE4_HALF_RAW;
	localparam int LINE3_HALF = (`SSB_LINE3_HALF_RAW < 1) ? 1 : `SSB_LINE3_HALF_RAW;
	localparam int TDM4_MIN = `SSB_TDM4_MIN_CYC;
	localparam int TDM4_MAX = `SSB_TDM4_MAX_CYC;
	localparam int TDM3_MIN = `SSB_TDM3_MIN_CYC;
	localparam int TDM3_MAX = `SSB_TDM3_MAX_CYC;
	localparam int SPI4_MIN = `SSB_SPI4_MIN_CYC;
	localparam int SPI3_MIN = `SSB_SPI3_MIN_CYC;
	localparam int SPI3_MAX = `SSB_SPI3_MAX_CYC;

	ssb_state_s q;
	ssb_state_s d;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic fifo_pop;
	logic active;
	logic [7:0] half;
	logic [15:0] tdm_cyc;
	logic [2:0] pin_raw;

	function automatic ssb_mode_e decode_mode(input logic [1:0] code);
		unique case (code)
			`SSB_MODE_CODE_FOUR: decode_mode = SSB_FOUR_WIRE;
			`SSB_MODE_CODE_THREE: decode_mode = SSB_THREE_WIRE;
			default: decode_mode = SSB_TDM;
		endcase
	endfunction

	function automatic logic [1:0] encode_mode(input ssb_mode_e m);
		unique case (m)
			SSB_FOUR_WIRE: encode_mode = `SSB_MODE_CODE_FOUR;
			SSB_THREE_WIRE: encode_mode = `SSB_MODE_CODE_THREE;
			SSB_TDM: encode_mode = `SSB_MODE_CODE_TDM;
		endcase
	endfunction

	assign active = (q.mode != SSB_TDM) && !i_bridge_reset;
	assign half = (q.mode == SSB_FOUR_WIRE) ? 8'(LINE4_HALF) : 8'(LINE3_HALF);
	assign tdm_cyc = {8'h00, i_tdm_div} * {7'h00, half, 1'b0};
	assign pin_raw = {i_line_int_n, i_pin_fs, i_pin_dr};
	assign fifo_pop = active && (q.tx_bits == 4'h0) && q.slot && (q.line_cnt == '0)
		&& !q.line_clk;

	ssb_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_pcm_fifo (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_in_valid(q.push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(q.pcm_shift),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_out_data)
	);

	always_comb begin
		logic tick;
		logic rise;
		tick = 1'b0;
		rise = 1'b0;
		d = q;
		d.push = 1'b0;

		// Each pin input is filtered: a change counts once stages two and three agree.
		for (int i = 0; i < 3; i++) begin
			d.sync[i] = {q.sync[i][1:0], pin_raw[i]};
			if (q.sync[i][1] == q.sync[i][2]) begin
				d.filt[i] = q.sync[i][2];
			end
		end

		// Mode may change only while the bridge is held in reset.
		if (i_bridge_reset) begin
			d.mode = decode_mode(i_mode_sel);
			d.line_cnt = '0;
			d.line_clk = 1'b0;
			d.slot = 1'b0;
			d.tdm_cnt = '0;
			d.tdm_clk = 1'b0;
			d.pcm_bits = '0;
			d.tx_bits = '0;
			d.spi_cnt = '0;
			d.cfg_err = 1'b0;
			d.spi_err = 1'b0;
			d.overrun = 1'b0;
		end else if (active) begin
			// Line clock divider; each rising line edge is one link bit.
			if (q.line_cnt == half - 8'h01) begin
				d.line_cnt = '0;
				d.line_clk = !q.line_clk;
				tick = !q.line_clk;
			end else begin
				d.line_cnt = q.line_cnt + 8'h01;
			end
		end

		if (tick) begin
			// Link bits alternate between a PCM slot and a control slot.
			d.slot = !q.slot;
			if (q.slot) begin
				d.miso_pend = q.filt[`SSB_SYNC_DR];
				if (q.tx_bits != 4'h0) begin
					d.link_dx = q.tx_byte[7];
					d.link_fs = (q.tx_bits == `SSB_PCM_BITS);
					d.tx_byte = {q.tx_byte[6:0], 1'b0};
					d.tx_bits = q.tx_bits - 4'h1;
				end else begin
					d.link_dx = 1'b0;
					d.link_fs = 1'b0;
				end
			end else begin
				d.dr_bit = q.filt[`SSB_SYNC_DR];
				d.link_dx = q.spi_bit;
				d.link_fs = 1'b0;
			end
			// TDM bit clock is the line clock divided by the programmed ratio.
			if (q.tdm_cnt >= i_tdm_div - 8'h01) begin
				d.tdm_cnt = '0;
				d.tdm_clk = 1'b1;
				// The on-chip controller's data and frame sync are taken once per TDM bit.
				if (i_tdm_fs || q.pcm_bits == `SSB_PCM_BITS - 4'h1) begin
					d.pcm_bits = i_tdm_fs ? 4'h1 : 4'h0;
					d.pcm_shift = {q.pcm_shift[6:0], i_tdm_transmit_data};
					d.push = !i_tdm_fs;
				end else begin
					d.pcm_bits = q.pcm_bits + 4'h1;
					d.pcm_shift = {q.pcm_shift[6:0], i_tdm_transmit_data};
				end
			end else begin
				d.tdm_cnt = q.tdm_cnt + 8'h01;
				if (q.tdm_cnt == {1'b0, i_tdm_div[7:1]}) begin
					d.tdm_clk = 1'b0;
				end
			end
		end
		if (fifo_pop && fifo_out_valid) begin
			d.tx_byte = fifo_out_data;
			d.tx_bits = `SSB_PCM_BITS;
		end
		// Without room the word is dropped and the loss stays flagged until bridge reset.
		if (q.push && !fifo_in_ready) begin
			d.overrun = 1'b1;
		end
		d.pcm_ready = fifo_in_ready;

		// TDM clock range check against the mode's limits.
		if (active) begin
			if (q.mode == SSB_FOUR_WIRE) begin
				if (tdm_cyc < 16'(TDM4_MIN) || tdm_cyc > 16'(TDM4_MAX)) begin
					d.cfg_err = 1'b1;
				end
			end else if (tdm_cyc < 16'(TDM3_MIN) || tdm_cyc > 16'(TDM3_MAX)) begin
				d.cfg_err = 1'b1;
			end
		end

		// SPI side of the bridge.
		d.sclk_prev = i_spi_sclk;
		d.cs_prev = i_spi_cs3_n;
		rise = i_spi_sclk && !q.sclk_prev;
		if (active && !i_spi_cs3_n) begin
			if (q.spi_per != 8'hFF) begin
				d.spi_per = q.spi_per + 8'h01;
			end
			if (rise) begin
				d.spi_bit = i_spi_mosi;
				d.miso = q.miso_pend;
				d.spi_cnt = q.spi_cnt + 4'h1;
				d.spi_per = 8'h01;
				if (q.spi_cnt != 4'h0) begin
					if (q.mode == SSB_FOUR_WIRE) begin
						if (q.spi_per < 8'(SPI4_MIN)) begin
							d.spi_err = 1'b1;
						end
					end else if (q.spi_per < 8'(SPI3_MIN) || q.spi_per > 8'(SPI3_MAX)) begin
						d.spi_err = 1'b1;
					end
				end
			end
		end else if (!i_bridge_reset) begin
			d.spi_bit = 1'b1;
			d.spi_per = '0;
		end
		// A frame ends when chip select 3 returns high; its bit count must match the mode.
		if (active && i_spi_cs3_n && !q.cs_prev) begin
			d.spi_cnt = '0;
			if (q.spi_cnt != ((q.mode == SSB_FOUR_WIRE) ? `SSB_SPI4_BITS : `SSB_SPI3_BITS)) begin
				d.spi_err = 1'b1;
			end
		end

		// Interrupt from the line chip, inverted after the pin filter.
		d.irq = active && (q.mode == SSB_FOUR_WIRE) && !q.filt[`SSB_SYNC_INT];

		// Pin ownership: exactly one function drives the shared pins.
		d.cs3_pin_n = (q.mode != SSB_TDM) ? 1'b1 : i_spi_cs3_n;
		unique case (q.mode)
			SSB_FOUR_WIRE: begin
				d.pin_ck = q.line_clk;
				d.pin_fs = q.link_fs;
				d.pin_fs_oe = 1'b1;
				d.pin_dx = q.link_dx;
				d.pin_dx_oe = 1'b1;
				d.fs_int = 1'b0;
			end
			SSB_THREE_WIRE: begin
				// Three pins only: clock, transmit and receive; frame sync is not driven.
				d.pin_ck = q.line_clk;
				d.pin_fs = 1'b0;
				d.pin_fs_oe = 1'b0;
				d.pin_dx = q.link_dx;
				d.pin_dx_oe = 1'b1;
				d.fs_int = 1'b0;
			end
			SSB_TDM: begin
				d.pin_ck = i_tdm_ck;
				d.pin_fs = i_tdm_fs;
				d.pin_fs_oe = i_tdm_fs_oe;
				d.pin_dx = i_tdm_transmit_data;
				d.pin_dx_oe = i_tdm_transmit_data_oe;
				d.dr_bit = q.filt[`SSB_SYNC_DR];
				d.fs_int = q.filt[`SSB_SYNC_FS];
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			q <= '{mode: SSB_TDM, sync: '1, filt: '1, tx_byte: '0, spi_bit: 1'b1,
				sclk_prev: 1'b0, cs_prev: 1'b1, cs3_pin_n: 1'b1, pcm_ready: 1'b0,
				default: '0};
		end else begin
			q <= d;
		end
	end

	// Loopback must not add a sampling delay, so the transmit pin value and its drive enable bypass the flops.
	assign o_pin_dx = i_ext_loopback ? i_pin_dr : q.pin_dx;
	assign o_pin_dx_oe = i_ext_loopback ? 1'b1 : q.pin_dx_oe;
	assign o_pin_ck = q.pin_ck;
	assign o_pin_fs = q.pin_fs;
	assign o_pin_fs_oe = q.pin_fs_oe;
	assign o_tdm_receive_data = q.dr_bit;
	assign o_tdm_fs = q.fs_int;
	assign o_tdm_bit_clk = q.tdm_clk;
	assign o_spi_miso = q.miso;
	assign o_spi_cs3_pin_n = q.cs3_pin_n;
	assign o_mode_active = encode_mode(q.mode);
	assign o_irq = q.irq;
	assign o_cfg_error = q.cfg_err;
	assign o_spi_error = q.spi_err;
	assign o_overrun = q.overrun;
	assign o_pcm_ready = q.pcm_ready;

endmodule

// >>> src/ssb_defs.svh
// Named constants of the line-interface serial bridge: rates, limits and field codes.
// Assumes the system clock runs at 100 MHz; all cycle counts derive from that figure.
`ifndef SSB_DEFS_SVH
`define SSB_DEFS_SVH

`define SSB_CEIL_DIV(a, b) (((a) + (b) - 1) / (b))

// Rates in kHz.
`define SSB_SYS_KHZ 100000
`define SSB_LINE4_KHZ 49152
`define SSB_LINE3_KHZ 24000
`define SSB_TDM4_MIN_KHZ 1024
`define SSB_TDM4_MAX_KHZ 8192
`define SSB_TDM3_MIN_KHZ 1536
`define SSB_TDM3_MAX_KHZ 2048
`define SSB_SPI4_MAX_KHZ 8192
`define SSB_SPI3_MIN_KHZ 3000
`define SSB_SPI3_MAX_KHZ 4000

// Derived cycle counts: shortest periods round up, longest round down.
`define SSB_LINE4_HALF_RAW (`SSB_SYS_KHZ / (2 * `SSB_LINE4_KHZ))
`define SSB_LINE3_HALF_RAW (`SSB_SYS_KHZ / (2 * `SSB_LINE3_KHZ))
`define SSB_TDM4_MIN_CYC `SSB_CEIL_DIV(`SSB_SYS_KHZ, `SSB_TDM4_MAX_KHZ)
`define SSB_TDM4_MAX_CYC (`SSB_SYS_KHZ / `SSB_TDM4_MIN_KHZ)
`define SSB_TDM3_MIN_CYC `SSB_CEIL_DIV(`SSB_SYS_KHZ, `SSB_TDM3_MAX_KHZ)
`define SSB_TDM3_MAX_CYC (`SSB_SYS_KHZ / `SSB_TDM3_MIN_KHZ)
`define SSB_SPI4_MIN_CYC `SSB_CEIL_DIV(`SSB_SYS_KHZ, `SSB_SPI4_MAX_KHZ)
`define SSB_SPI3_MIN_CYC `SSB_CEIL_DIV(`SSB_SYS_KHZ, `SSB_SPI3_MAX_KHZ)
`define SSB_SPI3_MAX_CYC (`SSB_SYS_KHZ / `SSB_SPI3_MIN_KHZ)

// SPI frame lengths per bridge variant.
`define SSB_SPI4_BITS 4'h8
`define SSB_SPI3_BITS 4'h9

// Mode field of the GPIO register at this offset, and its codes.
`define SSB_GPIO_MODE_OFFSET 12'h060
`define SSB_MODE_CODE_TDM 2'h0
`define SSB_MODE_CODE_FOUR 2'h1
`define SSB_MODE_CODE_THREE 2'h2

// PCM word width and sync stage layout.
`define SSB_PCM_BITS 4'h8
`define SSB_SYNC_DR 0
`define SSB_SYNC_FS 1
`define SSB_SYNC_INT 2

`endif

// >>> src/ssb_pkg.sv
// Types shared by the line-interface serial bridge.
// Assumes ssb_defs.svh sits on the include path.
`include "ssb_defs.svh"

package ssb_pkg;

	typedef enum logic [1:0] {
		SSB_TDM,
		SSB_FOUR_WIRE,
		SSB_THREE_WIRE
	} ssb_mode_e;

	typedef struct packed {
		ssb_mode_e mode;
		logic [2:0][2:0] sync;
		logic [2:0] filt;
		logic [7:0] line_cnt;
		logic line_clk;
		logic slot;
		logic [7:0] tdm_cnt;
		logic tdm_clk;
		logic [7:0] pcm_shift;
		logic [3:0] pcm_bits;
		logic push;
		logic [7:0] tx_byte;
		logic [3:0] tx_bits;
		logic link_dx;
		logic link_fs;
		logic sclk_prev;
		logic cs_prev;
		logic spi_bit;
		logic [3:0] spi_cnt;
		logic [7:0] spi_per;
		logic miso_pend;
		logic miso;
		logic dr_bit;
		logic irq;
		logic cfg_err;
		logic spi_err;
		logic overrun;
		logic pcm_ready;
		logic cs3_pin_n;
		logic pin_ck;
		logic pin_fs;
		logic pin_fs_oe;
		logic pin_dx;
		logic pin_dx_oe;
		logic fs_int;
	} ssb_state_s;

endpackage

// >>> src/ssb_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes both sides run on the one system clock.
`timescale 1ns/1ns

module ssb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic i_clock, // System clock.
	input wire logic i_reset, // Asynchronous reset, active high.
	input wire logic i_in_valid, // Word offered.
	output logic o_in_ready, // Room for a word.
	input wire logic [WIDTH-1:0] i_in_data, // Word written.
	output logic o_out_valid, // Word available.
	input wire logic i_out_ready, // Drain takes the word.
	output logic [WIDTH-1:0] o_out_data // Oldest word.
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic do_wr;
	logic do_rd;

	assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data = mem_q[rd_q];
	assign do_wr = i_in_valid && o_in_ready;
	assign do_rd = o_out_valid && i_out_ready;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_wr) begin
				wr_q <= bump(wr_q);
			end
			if (do_rd) begin
				rd_q <= bump(rd_q);
			end
			if (do_wr && !do_rd) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (do_rd && !do_wr) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	// Storage carries no reset; emptiness is tracked by the count alone.
	always_ff @(posedge i_clock) begin
		if (do_wr) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

endmodule

// >>> test/ssb_bridge_props.sv
// Concurrent checks on the serial bridge, seen from its ports only.
// Assumes one system clock and a bind onto every bridge instance.
`timescale 1ns/1ns
`include "ssb_defs.svh"

module ssb_bridge_props #(
	parameter int FIFO_DEPTH = 4
) (
	input logic i_clock,
	input logic i_reset,
	input logic [1:0] i_mode_sel,
	input logic i_bridge_reset,
	input logic i_ext_loopback,
	input logic i_tdm_transmit_data,
	input logic i_spi_cs3_n,
	input logic i_pin_dr,
	input logic i_line_int_n,
	input logic o_pin_dx,
	input logic o_pin_dx_oe,
	input logic o_spi_cs3_pin_n,
	input logic o_pin_ck,
	input logic o_pin_fs_oe,
	input logic [1:0] o_mode_active,
	input logic o_irq,
	input logic o_cfg_error,
	input logic o_spi_error,
	input logic o_overrun
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);

	sequence seq_run4;
		(o_mode_active == `SSB_MODE_CODE_FOUR && !i_bridge_reset && !o_cfg_error) [*4];
	endsequence
	sequence seq_run3;
		(o_mode_active == `SSB_MODE_CODE_THREE && !i_bridge_reset) [*4];
	endsequence
	sequence seq_int_low;
		(!i_line_int_n && o_mode_active == `SSB_MODE_CODE_FOUR && !i_bridge_reset) [*6];
	endsequence
	sequence seq_int_high;
		(i_line_int_n && o_mode_active == `SSB_MODE_CODE_FOUR && !i_bridge_reset) [*6];
	endsequence

	chk_loop_pass: assert property (i_ext_loopback |-> o_pin_dx == i_pin_dr && o_pin_dx_oe)
		else $error("loopback output differs from receive pin");
	chk_mode_latch: assert property (i_bridge_reset |=> o_mode_active ==
		(($past(i_mode_sel) == 2'h3) ? 2'h0 : $past(i_mode_sel)))
		else $error("mode in force differs from mode field");
	chk_mode_hold: assert property (!i_bridge_reset |=> $stable(o_mode_active))
		else $error("mode changed while bridge running");
	chk_cs3_internal: assert property (o_mode_active != 2'h0 && $past(o_mode_active) != 2'h0
		|-> o_spi_cs3_pin_n)
		else $error("select 3 pin active in bridge mode");
	chk_tdm_transmit_data_pass: assert property (o_mode_active == 2'h0 && $past(o_mode_active) == 2'h0
		&& !i_ext_loopback && !$past(i_reset) |-> o_pin_dx == $past(i_tdm_transmit_data))
		else $error("plain mode transmit pin not passed through");
	chk_tdm_cs_pass: assert property (o_mode_active == 2'h0 && $past(o_mode_active) == 2'h0
		&& !$past(i_reset) |-> o_spi_cs3_pin_n == $past(i_spi_cs3_n))
		else $error("plain mode select pin not passed through");
	chk_irq_raise: assert property (seq_int_low |=> o_irq)
		else $error("interrupt not raised from low line request");
	chk_irq_drop: assert property (seq_int_high |=> !o_irq)
		else $error("interrupt not inverted from high line level");
	chk_ck_four: assert property (seq_run4 |-> o_pin_ck != $past(o_pin_ck))
		else $error("four-wire line clock not toggling each cycle");
	chk_ck_three: assert property (seq_run3 ##0 $rose(o_pin_ck) |=> o_pin_ck ##1 !o_pin_ck)
		else $error("three-wire line clock half period wrong");
	chk_fs_three: assert property (o_mode_active == 2'h2 && $past(o_mode_active) == 2'h2
		|-> !o_pin_fs_oe)
		else $error("frame sync driven in three-wire mode");
	chk_err_clear: assert property (i_bridge_reset |=> !o_cfg_error && !o_spi_error && !o_overrun)
		else $error("error flags not cleared by bridge reset");
	chk_cfg_sticky: assert property (o_cfg_error && !i_bridge_reset |=> o_cfg_error)
		else $error("clock range error flag dropped");
	chk_spi_sticky: assert property (o_spi_error && !i_bridge_reset |=> o_spi_error)
		else $error("serial error flag dropped");
endmodule

bind ssb_bridge ssb_bridge_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
	.i_clock(i_clock), .i_reset(i_reset), .i_mode_sel(i_mode_sel),
	.i_bridge_reset(i_bridge_reset), .i_ext_loopback(i_ext_loopback), .i_tdm_transmit_data(i_tdm_transmit_data),
	.i_spi_cs3_n(i_spi_cs3_n), .i_pin_dr(i_pin_dr), .i_line_int_n(i_line_int_n),
	.o_pin_dx(o_pin_dx), .o_pin_dx_oe(o_pin_dx_oe), .o_spi_cs3_pin_n(o_spi_cs3_pin_n),
	.o_pin_ck(o_pin_ck), .o_pin_fs_oe(o_pin_fs_oe), .o_mode_active(o_mode_active),
	.o_irq(o_irq), .o_cfg_error(o_cfg_error), .o_spi_error(o_spi_error), .o_overrun(o_overrun)
);

// >>> test/ssb_line_model.sv
// Behavioural line-interface device at the far side of the bridge's pins.
// Assumes the bridge drives the line clock; data and frame sync move only on its rising edge.
`timescale 1ns/1ns

module ssb_line_model (
	input wire logic i_line_ck, // Line clock from the bridge.
	input wire logic i_int_req, // Bench asks for an interrupt.
	output logic o_dr, // Receive data towards the bridge.
	output logic o_fs, // Frame sync where the bridge leaves the pin.
	output logic o_int_n // Interrupt, active low.
);
	logic [7:0] pat = 8'hA5;
	logic [2:0] bit_cnt = 3'h0;

	initial begin
		o_dr = 1'h0;
		o_fs = 1'h0;
	end

	// Data launches on the rising line clock; a stopped clock freezes the pattern.
	always @(posedge i_line_ck) begin
		pat <= {pat[6:0], pat[7] ^ pat[5]};
		o_dr <= pat[7];
		bit_cnt <= bit_cnt + 3'h1;
		o_fs <= (bit_cnt == 3'h7);
	end

	// The model has no select input, since select 3 stays inside the chip in the bridge modes.
	assign o_int_n = !i_int_req;
endmodule

// >>> test/ssb_bridge_tb.sv
// Self-checking bench for the serial bridge: modes, pass-through, loopback, link and SPI.
// Assumes the line model stands at the pins and the checker is bound to the bridge.
`timescale 1ns/1ns

module ssb_bridge_tb;
	typedef struct {int due; int kind; logic [1:0] exp;} ssb_note_s;
	localparam int K_DX = 0, K_LOOP = 1, K_MODE = 2, K_CS3 = 3, K_IRQ = 4, K_CFG = 5, K_SPI = 6;
	localparam int K_FS = 7, K_OVR = 8, K_RDY = 9;
	logic i_clock = 1'h0, i_reset = 1'h1, i_bridge_reset = 1'h1, i_ext_loopback = 1'h0;
	logic [1:0] i_mode_sel = 2'h0;
	logic [7:0] i_tdm_div = 8'h08;
	logic i_tdm_ck = 1'h0, i_tdm_fs = 1'h0, i_tdm_fs_oe = 1'h0, i_tdm_transmit_data = 1'h0, i_tdm_transmit_data_oe = 1'h1;
	logic i_spi_sclk = 1'h0, i_spi_mosi = 1'h0, i_spi_cs3_n = 1'h1;
	logic int_req = 1'h0, dr_sel = 1'h0, dr_tb = 1'h0, model_dr, model_fs;
	logic i_pin_fs, i_pin_dr, i_line_int_n, o_pin_fs, o_pin_fs_oe, o_pin_dx, o_pin_dx_oe;
	logic o_pin_ck, o_spi_cs3_pin_n, o_irq, o_cfg_error, o_spi_error, o_overrun, o_pcm_ready;
	logic [1:0] o_mode_active;
	logic [31:0] rnd = 32'h78902518;
	int cyc = 0, n_errors = 0, checks_done = 0;
	ssb_note_s notes[$];
	ssb_note_s n;

	// The pin carries the bridge's value while it drives, the device's otherwise.
	assign i_pin_fs = o_pin_fs_oe ? o_pin_fs : model_fs;
	assign i_pin_dr = dr_sel ? dr_tb : model_dr;

	ssb_line_model u_line (.i_line_ck(o_pin_ck), .i_int_req(int_req), .o_dr(model_dr),
		.o_fs(model_fs), .o_int_n(i_line_int_n));

	ssb_bridge #(.FIFO_DEPTH(4)) u_dut (.i_clock, .i_reset, .i_mode_sel, .i_bridge_reset,
		.i_ext_loopback, .i_tdm_div, .i_tdm_ck, .i_tdm_fs, .i_tdm_fs_oe, .i_tdm_transmit_data, .i_tdm_transmit_data_oe,
		.o_tdm_receive_data(), .o_tdm_fs(), .o_tdm_bit_clk(), .i_spi_sclk, .i_spi_mosi, .i_spi_cs3_n,
		.o_spi_miso(), .o_spi_cs3_pin_n, .o_pin_ck, .o_pin_fs, .o_pin_fs_oe, .i_pin_fs,
		.o_pin_dx, .o_pin_dx_oe, .i_pin_dr, .i_line_int_n, .o_mode_active, .o_irq,
		.o_cfg_error, .o_spi_error, .o_overrun, .o_pcm_ready);

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic tick(input int c);
		repeat (c) @(posedge i_clock);
	endtask

	task automatic note(input int d, input int k, input logic [1:0] e);
		notes.push_back('{cyc + 1 + d, k, e});
	endtask

	task automatic cmp_bit(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic cmp_mode(input logic [1:0] e, input logic [1:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] o_mode_active expected %h seen %h", e, g);
		end
	endtask

	task automatic set_mode(input logic [1:0] m, input logic [7:0] div);
		tick(1);
		i_bridge_reset <= 1'h1;
		i_mode_sel <= m;
		i_tdm_div <= div;
		note(1, K_MODE, (m == 2'h3) ? 2'h0 : m);
		tick(3);
		note(0, K_CFG, 2'h0);
		note(0, K_SPI, 2'h0);
		// Select 3 idles high here, and a bridge mode holds the pin high as well.
		note(1, K_CS3, 2'h1);
		i_bridge_reset <= 1'h0;
	endtask

	task automatic run(input int c, input int chk);
		repeat (c) begin
			tick(1);
			rnd = lfsr_next(rnd);
			i_tdm_transmit_data <= rnd[0];
			i_tdm_fs <= rnd[1];
			i_tdm_ck <= rnd[2];
			if (chk) i_spi_cs3_n <= rnd[3];
			if (chk) note(1, K_DX, {1'h0, rnd[0]});
			if (chk) note(1, K_CS3, {1'h0, rnd[3]});
			if (chk) note(1, K_FS, {1'h0, rnd[1]});
		end
		tick(1);
		i_spi_cs3_n <= 1'h1;
	endtask

	task automatic spi_frame(input int bits, input int per);
		tick(1);
		i_spi_cs3_n <= 1'h0;
		for (int b = 0; b < bits; b++) begin
			tick(per / 2);
			rnd = lfsr_next(rnd);
			i_spi_sclk <= 1'h1;
			// A nine-bit word keeps its last bit zero, as the three-wire device expects.
			i_spi_mosi <= (bits == 9 && b == bits - 1) ? 1'h0 : rnd[0];
			tick(per / 2);
			i_spi_sclk <= 1'h0;
		end
		tick(per / 2);
		i_spi_cs3_n <= 1'h1;
		// One word per select, with a pause before the next word is offered.
		tick(6);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		forever #5 i_clock = ~i_clock;
	end

	always @(posedge i_clock) cyc <= cyc + 1;

	always @(negedge i_clock) begin
		while (notes.size() > 0 && notes[0].due <= cyc) begin
			n = notes.pop_front();
			case (n.kind)
				K_DX: cmp_bit("o_pin_dx", n.exp[0], o_pin_dx);
				K_LOOP: cmp_bit("o_pin_dx loop", n.exp[0], o_pin_dx);
				K_MODE: cmp_mode(n.exp, o_mode_active);
				K_CS3: cmp_bit("o_spi_cs3_pin_n", n.exp[0], o_spi_cs3_pin_n);
				K_IRQ: cmp_bit("o_irq", n.exp[0], o_irq);
				K_CFG: cmp_bit("o_cfg_error", n.exp[0], o_cfg_error);
				K_FS: cmp_bit("o_pin_fs", n.exp[0], o_pin_fs);
				K_OVR: cmp_bit("o_overrun", n.exp[0], o_overrun);
				K_RDY: cmp_bit("o_pcm_ready", n.exp[0], o_pcm_ready);
				default: cmp_bit("o_spi_error", n.exp[0], o_spi_error);
			endcase
		end
	end

	initial begin
		tick(12);
		i_reset <= 1'h0;
		set_mode(2'h0, 8'h08);
		run(40, 1);
		set_mode(2'h3, 8'h08);
		dr_sel <= 1'h1;
		i_ext_loopback <= 1'h1;
		repeat (16) begin
			tick(1);
			rnd = lfsr_next(rnd);
			dr_tb <= rnd[0];
			note(0, K_LOOP, {1'h0, rnd[0]});
		end
		tick(1);
		i_ext_loopback <= 1'h0;
		dr_sel <= 1'h0;
		set_mode(2'h1, 8'h08);
		run(200, 0);
		note(0, K_CFG, 2'h0);
		note(0, K_OVR, 2'h0);
		note(0, K_RDY, 2'h1);
		int_req <= 1'h1;
		tick(10);
		note(0, K_IRQ, 2'h1);
		int_req <= 1'h0;
		tick(10);
		note(0, K_IRQ, 2'h0);
		spi_frame(8, 14);
		note(0, K_SPI, 2'h0);
		spi_frame(7, 14);
		note(0, K_SPI, 2'h1);
		set_mode(2'h1, 8'h04);
		run(100, 0);
		note(0, K_CFG, 2'h1);
		set_mode(2'h2, 8'h0E);
		run(200, 0);
		note(0, K_CFG, 2'h0);
		note(0, K_OVR, 2'h0);
		note(0, K_RDY, 2'h1);
		spi_frame(9, 28);
		note(0, K_SPI, 2'h0);
		spi_frame(9, 20);
		note(0, K_SPI, 2'h1);
		set_mode(2'h2, 8'h0C);
		run(100, 0);
		note(0, K_CFG, 2'h1);
		tick(2);
		tally_and_finish();
	end

	// The tests take about fourteen hundred cycles; the limit leaves ample margin.
	initial begin
		tick(20000);
		n_errors++;
		tally_and_finish();
	end
endmodule
